// file: src/ep_kind_pkg.sv
// shared constants for the endpoint type configuration block
// assumes one 25 MHz register clock and an AHB-Lite bus in front
`default_nettype none
package ep_kind_pkg;
   localparam int EP_COUNT = 8;
   localparam int EP_IDX_W = 3;
   localparam int MPS_W = 11;
   localparam int ALLOC_W = 12;
   localparam int ADDR_W = 8;
   localparam int CFG_W = 5;
   localparam int CTRL_W = 16;

   // byte addresses of the register words
   localparam logic [ADDR_W-1:0] OFS_EP_INDEX = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_MAX_PKT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_KIND_CTRL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_EP_STATE = 8'h0C;

   // field positions of endpoint_kind_control
   localparam int BIT_NO_ZLP = 4;
   localparam int BIT_EP_EN = 3;
   localparam int BIT_DBL_BUF = 2;
   localparam int KIND_LSB = 0;

   // endpoint_kind_sel encodings
   localparam logic [1:0] KIND_UNUSED = 2'h0;
   localparam logic [1:0] KIND_ISO = 2'h1;
   localparam logic [1:0] KIND_BULK = 2'h2;
   localparam logic [1:0] KIND_INTR = 2'h3;

   localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
   localparam logic [CTRL_W-1:0] KIND_CTRL_RST = 16'h0000;
   localparam logic [MPS_W-1:0] MPS_RST = 11'h040;
   localparam logic [EP_IDX_W-1:0] EP_INDEX_RST = 3'h0;

   // read data phase holds hready low for this many cycles
   localparam logic [1:0] READ_WAIT = 2'h2;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0] {BUS_IDLE, BUS_READ} bus_state_e;
endpackage : ep_kind_pkg
`default_nettype wire

// file: src/ep_kind_ifs.sv
// carriers between the top module, its bus front end and mps memory
// assumes all parties share sys_clk and the clock enable
`default_nettype none
interface reg_req_if;
   import ep_kind_pkg::*;
   logic ce;
   logic wr_stb;
   logic [ADDR_W-1:0] wr_addr;
   logic [31:0] wr_data;
   logic [ADDR_W-1:0] rd_addr;
   logic [31:0] rd_data;
   modport front (input ce, rd_data, output wr_stb, wr_addr, wr_data,
      rd_addr);
   modport regs (output ce, rd_data, input wr_stb, wr_addr, wr_data,
      rd_addr);
endinterface : reg_req_if

interface mps_mem_if;
   import ep_kind_pkg::*;
   logic ce;
   logic we;
   logic [EP_IDX_W-1:0] wr_idx;
   logic [MPS_W-1:0] wr_data;
   logic [EP_IDX_W-1:0] cpu_idx;
   logic [MPS_W-1:0] cpu_rdata;
   logic [EP_IDX_W-1:0] eng_idx;
   logic [MPS_W-1:0] eng_rdata;
   modport mem (input ce, we, wr_idx, wr_data, cpu_idx, eng_idx,
      output cpu_rdata, eng_rdata);
   modport user (output ce, we, wr_idx, wr_data, cpu_idx, eng_idx,
      input cpu_rdata, eng_rdata);
endinterface : mps_mem_if
`default_nettype wire

// file: src/mps_mem.sv
// per-endpoint max packet size store, two registered read ports
// assumes writes and reads are synchronous to sys_clk
`default_nettype none
module mps_mem
   import ep_kind_pkg::*;
(
   input wire logic sys_clk, // register clock
   input wire logic rst_n, // async reset, active low
   mps_mem_if.mem m // write and read ports
);
   logic [MPS_W-1:0] mps_ff [EP_COUNT];
   logic [MPS_W-1:0] cpu_rdata_ff;
   logic [MPS_W-1:0] eng_rdata_ff;

   for (genvar i = 0; i < EP_COUNT; i++) begin : g_word
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            mps_ff[i] <= MPS_RST;
         end else if (m.ce && m.we && m.wr_idx == i) begin
            mps_ff[i] <= m.wr_data;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_rdata_ff <= MPS_RST;
         eng_rdata_ff <= MPS_RST;
      end else if (m.ce) begin
         cpu_rdata_ff <= mps_ff[m.cpu_idx];
         eng_rdata_ff <= mps_ff[m.eng_idx];
      end
   end

   assign m.cpu_rdata = cpu_rdata_ff;
   assign m.eng_rdata = eng_rdata_ff;
endmodule : mps_mem
`default_nettype wire

// file: src/ahb_front.sv
// AHB-Lite slave front end: writes with no wait, reads with two waits
// assumes single word transfers; response is always OKAY
`default_nettype none
module ahb_front
   import ep_kind_pkg::*;
(
   input wire logic sys_clk, // register clock
   input wire logic rst_n, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [ADDR_W-1:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic hready, // bus ready in
   input wire logic [31:0] hwdata, // write data
   output logic hreadyout, // slave ready
   output logic [31:0] hrdata, // read data
   output logic hresp, // always okay
   reg_req_if.front r // register side
);
   bus_state_e state_ff;
   logic [1:0] wait_ff;
   logic wr_phase_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic hreadyout_ff;
   logic [31:0] hrdata_ff;
   logic hresp_ff;

   wire take = hsel && hready && htrans == HTRANS_NONSEQ;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= BUS_IDLE;
         wait_ff <= 2'h0;
         wr_phase_ff <= 1'b0;
         addr_ff <= '0;
         hreadyout_ff <= 1'b1;
         hrdata_ff <= 32'h0000_0000;
         hresp_ff <= 1'b0;
      end else if (r.ce) begin
         case (state_ff)
            BUS_IDLE: begin
               wr_phase_ff <= take && hwrite;
               if (take) begin
                  addr_ff <= haddr;
               end
               if (take && !hwrite) begin
                  state_ff <= BUS_READ;
                  wait_ff <= READ_WAIT;
                  hreadyout_ff <= 1'b0;
               end
            end
            BUS_READ: begin
               wait_ff <= wait_ff - 2'h1;
               if (wait_ff == 2'h1) begin
                  hrdata_ff <= r.rd_data;
                  hreadyout_ff <= 1'b1;
                  state_ff <= BUS_IDLE;
               end
            end
            default: state_ff <= BUS_IDLE;
         endcase
      end
   end

   assign r.wr_stb = wr_phase_ff;
   assign r.wr_addr = addr_ff;
   assign r.wr_data = hwdata;
   assign r.rd_addr = addr_ff;
   assign hreadyout = hreadyout_ff;
   assign hrdata = hrdata_ff;
   assign hresp = hresp_ff;
endmodule : ahb_front
`default_nettype wire

// file: src/endpoint_type_config.sv
// per-endpoint type configuration registers of a USB peripheral
// assumes the packet engine and dma report events on sys_clk, one
// cycle pulses, and that software reaches us over AHB-Lite
//
// Summary of operation
// R1: with suppress_zero_len_pkt clear, a finished dma IN transfer makes the next IN token get a zero length packet, and with it set none is made.
// R2: endpoint enable at 1 activates the indexed endpoint fifo and at 0 deactivates it.
// R3: an enabled fifo is given buffer room sized from its max packet size.
// R4: a stall leaves the data toggle where it was, so it resumes from there.
// R5: clearing and then setting endpoint enable reinitialises that endpoint's data toggle.
// R6: double_buffer_en gives the endpoint two alternating buffers, else one.
// R7: endpoint_kind_sel picks 01 isochronous, 10 bulk, 11 interrupt, 00 unused.
// R8: software writes the reserved upper bits as zero, their reset value.
// R9: each endpoint has its own copy, and register access hits the indexed one.
//
// Added by the designer: register access over AHB-Lite.
`default_nettype none
module endpoint_type_config
   import ep_kind_pkg::*;
(
   input wire logic sys_clk, // register clock, 25 MHz
   input wire logic rst_n, // async reset, active low
   input wire logic clk_en, // freezes all state when low
   input wire logic hsel, // AHB-Lite slave select
   input wire logic [ADDR_W-1:0] haddr, // AHB-Lite address
   input wire logic [1:0] htrans, // AHB-Lite transfer type
   input wire logic hwrite, // AHB-Lite write
   input wire logic [2:0] hsize, // AHB-Lite size, word only
   input wire logic hready, // AHB-Lite ready in
   input wire logic [31:0] hwdata, // AHB-Lite write data
   output logic hreadyout, // AHB-Lite ready out
   output logic [31:0] hrdata, // AHB-Lite read data
   output logic hresp, // AHB-Lite response
   input wire logic [EP_IDX_W-1:0] eng_ep, // endpoint the engine serves
   input wire logic pkt_done, // packet acked on eng_ep
   input wire logic in_token, // IN token seen on eng_ep
   input wire logic dma_in_done, // dma IN transfer finished
   input wire logic [EP_IDX_W-1:0] dma_ep, // endpoint of that dma
   output logic [1:0] eng_kind, // transfer type of eng_ep
   output logic eng_fifo_en, // fifo of eng_ep active
   output logic eng_dbl_buf, // eng_ep double buffered
   output logic eng_buf_sel, // buffer in use on eng_ep
   output logic eng_toggle, // data toggle of eng_ep
   output logic [ALLOC_W-1:0] eng_alloc_bytes, // room kept for eng_ep
   output logic send_zlp // answer this IN with a zero length packet
);
   // hsize is accepted but not checked: only word transfers are issued
   reg_req_if rq ();
   mps_mem_if mm ();

   logic [EP_IDX_W-1:0] ep_index_ff;
   logic [CFG_W-1:0] cfg_ff [EP_COUNT];
   logic [EP_COUNT-1:0] toggle_ff;
   logic [EP_COUNT-1:0] buf_sel_ff;
   logic [EP_COUNT-1:0] zlp_pend_ff;

   logic [1:0] eng_kind_ff;
   logic eng_fifo_en_ff;
   logic eng_dbl_buf_ff;
   logic eng_buf_sel_ff;
   logic eng_toggle_ff;
   logic [ALLOC_W-1:0] eng_alloc_ff;
   logic send_zlp_ff;
   logic alloc_en_ff;
   logic alloc_dbl_ff;

   ahb_front u_front (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hready(hready),
      .hwdata(hwdata),
      .hreadyout(hreadyout),
      .hrdata(hrdata),
      .hresp(hresp),
      .r(rq.front)
   );

   mps_mem u_mps (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .m(mm.mem)
   );

   // address decode of the write strobe
   wire wr_index = rq.wr_stb && rq.wr_addr == OFS_EP_INDEX;
   wire wr_mps = rq.wr_stb && rq.wr_addr == OFS_MAX_PKT;
   wire wr_kind = rq.wr_stb && rq.wr_addr == OFS_KIND_CTRL;

   // R8 reserved bits dropped
   wire [CFG_W-1:0] wr_cfg = rq.wr_data[CFG_W-1:0];
   wire new_en = wr_cfg[BIT_EP_EN];

   // R9 indexed copy selected
   wire [CFG_W-1:0] idx_cfg = cfg_ff[ep_index_ff];
   wire [CFG_W-1:0] eng_cfg = cfg_ff[eng_ep];

   wire [31:0] rd_index = {{(32 - EP_IDX_W){1'b0}}, ep_index_ff};
   wire [31:0] rd_mps = {{(32 - MPS_W){1'b0}}, mm.cpu_rdata};
   wire [31:0] rd_kind = {{(32 - CFG_W){1'b0}}, idx_cfg};
   wire [31:0] rd_state = {29'h0000_0000, zlp_pend_ff[ep_index_ff],
      buf_sel_ff[ep_index_ff], toggle_ff[ep_index_ff]};

   // unmapped addresses read as zero, writes to them are dropped
   logic [31:0] rd_mux;
   always_comb begin
      if (rq.rd_addr == OFS_EP_INDEX) begin
         rd_mux = rd_index;
      end else if (rq.rd_addr == OFS_MAX_PKT) begin
         rd_mux = rd_mps;
      end else if (rq.rd_addr == OFS_KIND_CTRL) begin
         rd_mux = rd_kind;
      end else if (rq.rd_addr == OFS_EP_STATE) begin
         rd_mux = rd_state;
      end else begin
         rd_mux = 32'h0000_0000;
      end
   end

   assign rq.ce = clk_en;
   assign rq.rd_data = rd_mux;

   assign mm.ce = clk_en;
   assign mm.we = wr_mps;
   assign mm.wr_idx = ep_index_ff;
   assign mm.wr_data = rq.wr_data[MPS_W-1:0];
   assign mm.cpu_idx = ep_index_ff;
   assign mm.eng_idx = eng_ep;

   // R9 one shared index; writing it retargets every later access
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ep_index_ff <= EP_INDEX_RST;
      end else if (clk_en && wr_index) begin
         ep_index_ff <= rq.wr_data[EP_IDX_W-1:0];
      end
   end

   // per-endpoint configuration and run state
   for (genvar i = 0; i < EP_COUNT; i++) begin : g_ep
      wire wr_hit = wr_kind && ep_index_ff == i;
      wire en_now = cfg_ff[i][BIT_EP_EN];
      wire dbl_now = cfg_ff[i][BIT_DBL_BUF];
      wire pkt_hit = pkt_done && eng_ep == i && en_now;
      wire in_hit = in_token && eng_ep == i && en_now;
      // R1 zero length armed
      wire zlp_set = dma_in_done && dma_ep == i && en_now &&
         !cfg_ff[i][BIT_NO_ZLP];
      // R5 enable edge seen
      wire en_flip = wr_hit && new_en != en_now;

      // R7 kind held per endpoint
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            cfg_ff[i] <= CFG_RST;
         end else if (clk_en && wr_hit) begin
            cfg_ff[i] <= wr_cfg;
         end
      end

      // R5 toggle reinitialised
      // R4 stall keeps toggle
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            toggle_ff[i] <= 1'b0;
         end else if (clk_en) begin
            if (en_flip) begin
               toggle_ff[i] <= 1'b0;
            end else if (pkt_hit) begin
               toggle_ff[i] <= ~toggle_ff[i];
            end
         end
      end

      // R6 buffers alternate
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            buf_sel_ff[i] <= 1'b0;
         end else if (clk_en) begin
            if (wr_hit && (!new_en || !wr_cfg[BIT_DBL_BUF])) begin
               buf_sel_ff[i] <= 1'b0;
            end else if (pkt_hit && dbl_now) begin
               buf_sel_ff[i] <= ~buf_sel_ff[i];
            end
         end
      end

      // R1 set wins over clear
      always_ff @(posedge sys_clk or negedge rst_n) begin
         if (!rst_n) begin
            zlp_pend_ff[i] <= 1'b0;
         end else if (clk_en) begin
            if (zlp_set) begin
               zlp_pend_ff[i] <= 1'b1;
            end else if (in_hit || (wr_hit && !new_en)) begin
               zlp_pend_ff[i] <= 1'b0;
            end
         end
      end
   end

   // R2 fifo active only when enabled
   wire eng_en = eng_cfg[BIT_EP_EN];
   wire zlp_fire = in_token && eng_en && zlp_pend_ff[eng_ep];

   // R7 kind of the served endpoint
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_kind_ff <= KIND_UNUSED;
      end else if (clk_en) begin
         eng_kind_ff <= eng_cfg[KIND_LSB +: 2];
      end
   end

   // R2 fifo state of the served endpoint
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_fifo_en_ff <= 1'b0;
      end else if (clk_en) begin
         eng_fifo_en_ff <= eng_en;
      end
   end

   // R6 buffer mode of the served endpoint
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_dbl_buf_ff <= 1'b0;
      end else if (clk_en) begin
         eng_dbl_buf_ff <= eng_cfg[BIT_DBL_BUF];
      end
   end

   // R6 buffer now in use
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_buf_sel_ff <= 1'b0;
      end else if (clk_en) begin
         eng_buf_sel_ff <= buf_sel_ff[eng_ep];
      end
   end

   // R4 toggle of the served endpoint
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_toggle_ff <= 1'b0;
      end else if (clk_en) begin
         eng_toggle_ff <= toggle_ff[eng_ep];
      end
   end

   // R1 zero length reply, one cycle
   // registered so the reply lines up with eng_toggle for the same token
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         send_zlp_ff <= 1'b0;
      end else if (clk_en) begin
         send_zlp_ff <= zlp_fire;
      end
   end

   // R3 room from max packet size
   // the mps read port is registered, so enable and double are
   // delayed one cycle to line up with it
   wire [ALLOC_W-1:0] mps_wide = {1'b0, mm.eng_rdata};
   wire [ALLOC_W-1:0] alloc_next = !alloc_en_ff ? '0 :
      alloc_dbl_ff ? mps_wide << 1 : mps_wide;

   // R3 enable as seen by the allocator
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         alloc_en_ff <= 1'b0;
      end else if (clk_en) begin
         alloc_en_ff <= eng_en;
      end
   end

   // R6 doubling as seen by the allocator
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         alloc_dbl_ff <= 1'b0;
      end else if (clk_en) begin
         alloc_dbl_ff <= eng_cfg[BIT_DBL_BUF];
      end
   end

   // R3 room kept for the served endpoint
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         eng_alloc_ff <= '0;
      end else if (clk_en) begin
         eng_alloc_ff <= alloc_next;
      end
   end

   assign eng_kind = eng_kind_ff;
   assign eng_fifo_en = eng_fifo_en_ff;
   assign eng_dbl_buf = eng_dbl_buf_ff;
   assign eng_buf_sel = eng_buf_sel_ff;
   assign eng_toggle = eng_toggle_ff;
   assign eng_alloc_bytes = eng_alloc_ff;
   assign send_zlp = send_zlp_ff;
endmodule : endpoint_type_config
`default_nettype wire

// file: verif/ep_kind_properties.sv
// checker for the endpoint type block, top module ports only
// assumes one clock domain and an active low reset
`default_nettype none
module ep_kind_properties
   import ep_kind_pkg::*;
(
   input wire logic sys_clk, // clock
   input wire logic rst_n, // reset
   input wire logic clk_en, // run
   input wire logic hsel, // select
   input wire logic [1:0] htrans, // type
   input wire logic hwrite, // write
   input wire logic hready, // ready in
   input wire logic hreadyout, // ready out
   input wire logic [31:0] hrdata, // read data
   input wire logic hresp, // response
   input wire logic in_token, // IN token
   input wire logic [1:0] eng_kind, // kind
   input wire logic eng_fifo_en, // fifo on
   input wire logic eng_toggle, // toggle
   input wire logic send_zlp // zero length reply
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire logic take = hsel && hready && clk_en && htrans == HTRANS_NONSEQ;

   a_hresp_okay:
      assert property (hresp == 1'b0) else $error("hresp not okay");
   a_write_nowait:
      assert property (take && hwrite |=> hreadyout)
      else $error("write waited");
   a_read_waits:
      assert property (take && !hwrite |=> !hreadyout ##1 !hreadyout
         ##1 hreadyout) else $error("read wait count wrong");
   a_rdata_holds:
      assert property (!$rose(hreadyout) |-> $stable(hrdata))
      else $error("hrdata moved without a read");
   a_reset_quiet:
      assert property ($rose(rst_n) |-> hreadyout && !send_zlp &&
         !eng_fifo_en && !eng_toggle && eng_kind == KIND_UNUSED)
      else $error("outputs not at reset value");
   a_zlp_cause:
      assert property (send_zlp |-> $past(in_token) && $past(clk_en))
      else $error("zero length reply without token");
   a_zlp_pulse:
      assert property (send_zlp && clk_en |=> !send_zlp)
      else $error("zero length reply too long");
   a_freeze_state:
      assert property (!clk_en |=> $stable({eng_kind, eng_fifo_en,
         eng_toggle, send_zlp, hreadyout})) else $error("moved while frozen");
   cover property (take && !hwrite);
   cover property (send_zlp);
   cover property (!clk_en ##1 clk_en);
endmodule : ep_kind_properties

bind endpoint_type_config ep_kind_properties i_props (.sys_clk(sys_clk),
   .rst_n(rst_n), .clk_en(clk_en), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
   .hrdata(hrdata), .hresp(hresp), .in_token(in_token),
   .eng_kind(eng_kind), .eng_fifo_en(eng_fifo_en),
   .eng_toggle(eng_toggle), .send_zlp(send_zlp));
`default_nettype wire

// file: verif/token_host.sv
// model of the usb host and dma side feeding the packet engine events
// assumes tasks are called from the bench; events are one cycle pulses
`default_nettype none
module token_host
   import ep_kind_pkg::*;
(
   input wire logic sys_clk, // clock
   output logic [EP_IDX_W-1:0] eng_ep, // served endpoint
   output logic pkt_done, // packet acked
   output logic in_token, // IN token
   output logic dma_in_done, // dma finished
   output logic [EP_IDX_W-1:0] dma_ep // dma endpoint
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      eng_ep = 3'h0;
      pkt_done = 1'b0;
      in_token = 1'b0;
      dma_in_done = 1'b0;
      dma_ep = 3'h7;
   end
   task automatic serve(input logic [EP_IDX_W-1:0] ep);
      @(posedge sys_clk);
      eng_ep <= ep;
   endtask : serve
   task automatic ack();
      @(posedge sys_clk);
      pkt_done <= 1'b1;
      @(posedge sys_clk);
      pkt_done <= 1'b0;
   endtask : ack
   task automatic tok();
      @(posedge sys_clk);
      in_token <= 1'b1;
      @(posedge sys_clk);
      in_token <= 1'b0;
   endtask : tok
   // the endpoint number is not held after the pulse, so show its inverse
   task automatic dma(input logic [EP_IDX_W-1:0] ep);
      @(posedge sys_clk);
      dma_in_done <= 1'b1;
      dma_ep <= ep;
      @(posedge sys_clk);
      dma_in_done <= 1'b0;
      dma_ep <= ~ep;
   endtask : dma
endmodule : token_host
`default_nettype wire

// file: verif/tb.sv
// self-checking bench: AHB-Lite register access plus engine events
// assumes the design answers writes at once and reads after two waits
`default_nettype none
`define CHK(nm, ex, ac) begin checks_done++; if ((ac) !== (ex)) begin \
   n_mismatch++; $display("Error %s: expected %h, seen %h", nm, ex, ac); \
   end end
module tb
   import ep_kind_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, rst_n, clk_en, hsel, hwrite, hreadyout, hresp;
   logic [ADDR_W-1:0] haddr;
   logic [1:0] htrans, eng_kind;
   logic [31:0] hwdata, hrdata;
   logic [EP_IDX_W-1:0] eng_ep, dma_ep;
   logic pkt_done, in_token, dma_in_done, eng_fifo_en, eng_dbl_buf;
   logic eng_buf_sel, eng_toggle, send_zlp;
   logic [ALLOC_W-1:0] eng_alloc_bytes;
   logic [2:0] hsize;
   logic [4:0] cfgv [4];
   int n_mismatch = 0;
   int checks_done = 0;

   endpoint_type_config i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
      .clk_en(clk_en), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .eng_ep(eng_ep), .pkt_done(pkt_done), .in_token(in_token),
      .dma_in_done(dma_in_done), .dma_ep(dma_ep), .eng_kind(eng_kind),
      .eng_fifo_en(eng_fifo_en), .eng_dbl_buf(eng_dbl_buf),
      .eng_buf_sel(eng_buf_sel), .eng_toggle(eng_toggle),
      .eng_alloc_bytes(eng_alloc_bytes), .send_zlp(send_zlp));
   token_host i_host (.sys_clk(sys_clk), .eng_ep(eng_ep),
      .pkt_done(pkt_done), .in_token(in_token),
      .dma_in_done(dma_in_done), .dma_ep(dma_ep));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // address phase held until hready, then data phase held likewise
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      hsize <= 3'h2;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic chk_rd(input logic [ADDR_W-1:0] a,
      input logic [31:0] ex, input string nm);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      `CHK(nm, ex, q)
   endtask : chk_rd
   // upper reserved bits always go out as zero
   task automatic cfg(input int ep, input logic [4:0] v);
      wr(OFS_EP_INDEX, ep);
      wr(OFS_KIND_CTRL, {27'h0, v});
   endtask : cfg
   task automatic chk_eng(input int e, input logic [ALLOC_W-1:0] mps);
      logic [4:0] v;
      logic [ALLOC_W-1:0] room;
      v = cfgv[e];
      room = v[BIT_EP_EN] ? (v[BIT_DBL_BUF] ? mps << 1 : mps) : 12'h000;
      i_host.serve(e[EP_IDX_W-1:0]);
      repeat (3) @(posedge sys_clk);
      #1;
      `CHK("eng_kind", v[1:0], eng_kind)
      `CHK("eng_fifo_en", v[BIT_EP_EN], eng_fifo_en)
      `CHK("eng_dbl_buf", v[BIT_DBL_BUF], eng_dbl_buf)
      `CHK("eng_alloc_bytes", room, eng_alloc_bytes)
   endtask : chk_eng

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      report_and_stop();
   end

   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hsize = 3'h2;
      hwrite = 1'b0;
      hwdata = 32'h0000_0000;
      cfgv = '{5'h00, 5'h0D, 5'h0A, 5'h07};
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      chk_rd(OFS_KIND_CTRL, KIND_CTRL_RST, "kind reset");
      chk_rd(OFS_MAX_PKT, MPS_RST, "mps reset");
      wr(OFS_EP_INDEX, 32'h0000_0002);
      wr(OFS_MAX_PKT, 32'h0000_0100);
      for (int e = 0; e < 4; e++) cfg(e, cfgv[e]);
      for (int e = 0; e < 4; e++) begin
         wr(OFS_EP_INDEX, e);
         chk_rd(OFS_KIND_CTRL, cfgv[e], "kind ctrl");
      end
      wr(8'h10, 32'hFFFF_FFFF);
      chk_rd(8'h10, 32'h0000_0000, "unmapped");
      for (int e = 0; e < 4; e++) chk_eng(e, e == 2 ? 12'h100 : MPS_RST);
      i_host.serve(3'h1);
      i_host.ack();
      repeat (2) @(posedge sys_clk);
      #1 `CHK("toggle", 1'b1, eng_toggle)
      `CHK("buf_sel", 1'b1, eng_buf_sel)
      // rewriting with enable unchanged must not disturb the toggle
      cfg(1, cfgv[1]);
      chk_rd(OFS_EP_STATE, 32'h0000_0003, "state kept");
      cfg(1, 5'h05);
      cfg(1, cfgv[1]);
      chk_rd(OFS_EP_STATE, 32'h0000_0000, "state reinit");
      #1 `CHK("toggle reinit", 1'b0, eng_toggle)
      i_host.serve(3'h2);
      i_host.dma(3'h2);
      i_host.tok();
      #1 `CHK("zlp", 1'b1, send_zlp)
      i_host.tok();
      #1 `CHK("zlp again", 1'b0, send_zlp)
      cfg(2, 5'h1A);
      i_host.dma(3'h2);
      i_host.tok();
      #1 `CHK("zlp off", 1'b0, send_zlp)
      i_host.serve(3'h3);
      i_host.dma(3'h3);
      i_host.ack();
      i_host.tok();
      #1 `CHK("zlp disabled", 1'b0, send_zlp)
      `CHK("toggle disabled", 1'b0, eng_toggle)
      @(posedge sys_clk);
      clk_en <= 1'b0;
      i_host.serve(3'h1);
      i_host.ack();
      repeat (3) @(posedge sys_clk);
      #1 `CHK("frozen kind", KIND_INTR, eng_kind)
      @(posedge sys_clk);
      clk_en <= 1'b1;
      repeat (3) @(posedge sys_clk);
      #1 `CHK("kind after run", KIND_ISO, eng_kind)
      `CHK("toggle after run", 1'b0, eng_toggle)
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      wr(OFS_EP_INDEX, 32'h0000_0001);
      chk_rd(OFS_KIND_CTRL, KIND_CTRL_RST, "kind after reset");
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
